// ==== rtl/ict_cfg.svh ====
// Register map, field positions and reset values of the input capture timer.
`ifndef ICT_CFG_SVH
`define ICT_CFG_SVH
// Register byte offsets.
`define ICT_OFF_CTRL 8'h00
`define ICT_OFF_CFG_LO 8'h04
`define ICT_OFF_CFG_HI 8'h08
`define ICT_OFF_COUNT 8'h0C
`define ICT_OFF_CAP0 8'h10
`define ICT_OFF_CAP4 8'h20
`define ICT_OFF_CAP5 8'h24
`define ICT_OFF_IRQ_STAT 8'h34
`define ICT_OFF_IRQ_MASK 8'h38
// Control register bits.
`define ICT_CTRL_ACTIVE 0
`define ICT_CTRL_ENABLE 1
`define ICT_CTRL_RESET 2
// Fields inside one channel byte of a config word.
`define ICT_FLD_EDGE_LO 0
`define ICT_FLD_EDGE_HI 1
`define ICT_FLD_SKIP 2
`define ICT_FLD_FCLK_LO 5
`define ICT_FLD_FCLK_HI 7
// Byte position of each channel inside its config word.
`define ICT_CH0_BYTE_LO 0
`define ICT_CH4_BYTE_LO 0
`define ICT_CH5_BYTE_LO 8
// Absolute bits of the channel 5 edge field, kept apart as a cross-check of the byte split.
`define ICT_CH5_EDGE_HI 9
`define ICT_CH5_EDGE_LO 8
// Writable bits of the config words; reserved bits read zero.
`define ICT_CFG_LO_MASK 32'h000000E7
`define ICT_CFG_HI_MASK 32'h0000E7E7
// Interrupt status bit positions.
`define ICT_IRQ_WRAP 0
`define ICT_IRQ_CAP0 1
`define ICT_IRQ_CAP4 2
`define ICT_IRQ_CAP5 3
// Reset values and counter extremes.
`define ICT_ZERO32 32'h00000000
`define ICT_ONES32 32'hFFFFFFFF
`define ICT_ZERO4 4'h0
`endif

// ==== rtl/ict_pkg.sv ====
// Types shared by the input capture timer.
package ict_pkg;
  // Edge choice encoding of a capture channel.
  typedef enum logic [1:0] {
    ICT_EDGE_FALL = 2'h0,
    ICT_EDGE_RISE = 2'h1,
    ICT_EDGE_BOTH = 2'h2,
    ICT_EDGE_OFF = 2'h3
  } ict_edge_t;
endpackage : ict_pkg

// ==== rtl/ict_timer.sv ====
// Free-running 32-bit timer with three input capture channels and a register port.
`timescale 1ns/1ps
`include "ict_cfg.svh"
// Overview of operation
// - Each channel has a 2-bit edge field: ch0/ch4 bits 1:0, ch5 bits 9:8.
// - Edge field: 0 falling, 1 rising, 2 both edges, 3 capture disabled.
// - Filter skip bit (2, or 10 for ch5) set feeds the synchronised input past filter.
// - A 3-bit field, bits 7:5 or 15:13, picks the filter sample rate.
// - The running 32-bit counter value is readable as a register.
// - Counter wrap from all ones to zero raises the timer interrupt.
// - Counter writes are ignored while enabled and loaded while disabled.
// - A programmed edge on input 0 copies the counter into capture register 0.
// - Counter reset bit stops and zeroes the counter, then clears itself.
// - Enable starts and stops counting; it is cleared after a counter reset.
// - Counter starts at zero, counts upward and wraps to zero after maximum.
module ict_timer #(
  parameter int FILT_LEN = 4,
  parameter int DIV_W = 8
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Capture input pins.
  input wire logic capture_input_ch0,
  input wire logic capture_input_ch4,
  input wire logic capture_input_ch5,
  // Interrupt to the aggregator.
  output logic irq
);

  // A filter needs at least one stable sample and the divider must cover all eight rates.
  if (FILT_LEN < 1 || FILT_LEN > 255 || DIV_W < 8) begin : g_bad_param
    $error("ict_timer: FILT_LEN must be 1..255 and DIV_W at least 8");
  end

  // Per-channel field extraction from one config byte.
  function automatic logic [1:0] f_edge(input logic [7:0] b);
    f_edge = b[`ICT_FLD_EDGE_HI:`ICT_FLD_EDGE_LO];
  endfunction : f_edge

  function automatic logic [2:0] f_fclk(input logic [7:0] b);
    f_fclk = b[`ICT_FLD_FCLK_HI:`ICT_FLD_FCLK_LO];
  endfunction : f_fclk

  // Edge decode shared by all channels.
  function automatic logic f_hit(input logic [1:0] sel, input logic prev, input logic cur);
    case (ict_pkg::ict_edge_t'(sel))
      ict_pkg::ICT_EDGE_FALL: f_hit = prev & ~cur;
      ict_pkg::ICT_EDGE_RISE: f_hit = ~prev & cur;
      ict_pkg::ICT_EDGE_BOTH: f_hit = prev ^ cur;
      default: f_hit = 1'b0;
    endcase
  endfunction : f_hit

  logic [31:0] cfg_lo_ff;
  logic [31:0] cfg_hi_ff;
  logic active_ff;
  logic enable_ff;
  logic cnt_rst_ff;
  logic [31:0] count_ff;
  logic [31:0] cap_ff [3];
  logic [3:0] irq_stat_ff;
  logic [3:0] irq_mask_ff;
  logic [31:0] reg_rdata_ff;
  logic irq_ff;
  logic [DIV_W-1:0] div_ff;
  logic [2:0] pin;
  logic [7:0] ch_cfg [3];
  logic [2:0] cap_evt;
  logic wrap_evt;
  logic wr_ctrl;
  logic wr_count;
  logic [3:0] nxt_irq_stat;
  logic [31:0] nxt_rdata;

  assign pin = {capture_input_ch5, capture_input_ch4, capture_input_ch0};
  assign ch_cfg[0] = cfg_lo_ff[`ICT_CH0_BYTE_LO +: 8];
  assign ch_cfg[1] = cfg_hi_ff[`ICT_CH4_BYTE_LO +: 8];
  assign ch_cfg[2] = cfg_hi_ff[`ICT_CH5_BYTE_LO +: 8];
  assign wr_ctrl = reg_wr && reg_addr == `ICT_OFF_CTRL;
  assign wr_count = reg_wr && reg_addr == `ICT_OFF_COUNT;
  assign wrap_evt = active_ff && enable_ff && !cnt_rst_ff && count_ff == `ICT_ONES32;

  // Shared prescaler; the filter of each channel samples on one of its taps.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end

  // Per-channel input path: synchroniser, optional filter, edge detector.
  for (genvar c = 0; c < 3; c++) begin : g_ch
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic clean_ff;
    logic filt_ff;
    logic prev_ff;
    logic [7:0] run_ff;
    logic tick;
    logic level;
    logic [DIV_W-1:0] tap_mask;

    // Three flops; the level only changes once the last two agree, so the
    // first stage never feeds anything but the second.
    always_ff @(posedge mclk) begin
      if (!rst_b) begin
        s1_ff <= 1'b0;
        s2_ff <= 1'b0;
        s3_ff <= 1'b0;
        clean_ff <= 1'b0;
      end else begin
        s1_ff <= pin[c];
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        if (s2_ff == s3_ff) begin
          clean_ff <= s3_ff;
        end
      end
    end

    // The chosen rate ticks once every 2**sel clocks.
    assign tap_mask = DIV_W'((1 << f_fclk(ch_cfg[c])) - 1);
    assign tick = (div_ff & tap_mask) == '0;

    // Noise filter: a new level must hold for FILT_LEN sampling ticks.
    always_ff @(posedge mclk) begin
      if (!rst_b) begin
        filt_ff <= 1'b0;
        run_ff <= '0;
      end else if (tick) begin
        if (clean_ff == filt_ff) begin
          run_ff <= '0;
        end else if (run_ff == 8'(FILT_LEN - 1)) begin
          filt_ff <= clean_ff;
          run_ff <= '0;
        end else begin
          run_ff <= run_ff + 8'h01;
        end
      end
    end

    // Bypass trades noise immunity for latency of a few clocks.
    assign level = ch_cfg[c][`ICT_FLD_SKIP] ? clean_ff : filt_ff;

    always_ff @(posedge mclk) begin
      if (!rst_b) begin
        prev_ff <= 1'b0;
      end else begin
        prev_ff <= level;
      end
    end

    // An edge counts only while the timer block is active.
    assign cap_evt[c] = active_ff && f_hit(f_edge(ch_cfg[c]), prev_ff, level);

    // Capture copies the counter as it stands in the detecting cycle.
    always_ff @(posedge mclk) begin
      if (!rst_b) begin
        cap_ff[c] <= `ICT_ZERO32;
      end else if (cap_evt[c]) begin
        cap_ff[c] <= count_ff;
      end
    end
  end

  // Configuration words; reserved bits are never stored.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cfg_lo_ff <= `ICT_ZERO32;
      cfg_hi_ff <= `ICT_ZERO32;
    end else if (reg_wr && reg_addr == `ICT_OFF_CFG_LO) begin
      cfg_lo_ff <= reg_wdata & `ICT_CFG_LO_MASK;
    end else if (reg_wr && reg_addr == `ICT_OFF_CFG_HI) begin
      cfg_hi_ff <= reg_wdata & `ICT_CFG_HI_MASK;
    end
  end

  // Control bits. The reset bit self-clears one cycle after it is set and
  // takes the enable with it, so software must see it low before re-enabling.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      active_ff <= 1'b0;
      enable_ff <= 1'b0;
      cnt_rst_ff <= 1'b0;
    end else if (cnt_rst_ff) begin
      cnt_rst_ff <= 1'b0;
      enable_ff <= 1'b0;
      if (wr_ctrl) begin
        active_ff <= reg_wdata[`ICT_CTRL_ACTIVE];
      end
    end else if (wr_ctrl) begin
      active_ff <= reg_wdata[`ICT_CTRL_ACTIVE];
      enable_ff <= reg_wdata[`ICT_CTRL_ENABLE];
      cnt_rst_ff <= reg_wdata[`ICT_CTRL_RESET];
    end
  end

  // Free-running counter; a pending reset beats a software load and counting.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      count_ff <= `ICT_ZERO32;
    end else if (cnt_rst_ff) begin
      count_ff <= `ICT_ZERO32;
    end else if (wr_count && !enable_ff) begin
      count_ff <= reg_wdata;
    end else if (active_ff && enable_ff) begin
      count_ff <= count_ff + 32'h00000001;
    end
  end

  // Sticky status: a new event in the clearing cycle wins over the clear.
  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    if (reg_wr && reg_addr == `ICT_OFF_IRQ_STAT) begin
      nxt_irq_stat = irq_stat_ff & ~reg_wdata[`ICT_IRQ_CAP5:`ICT_IRQ_WRAP];
    end
    nxt_irq_stat[`ICT_IRQ_WRAP] = nxt_irq_stat[`ICT_IRQ_WRAP] | wrap_evt;
    nxt_irq_stat[`ICT_IRQ_CAP0] = nxt_irq_stat[`ICT_IRQ_CAP0] | cap_evt[0];
    nxt_irq_stat[`ICT_IRQ_CAP4] = nxt_irq_stat[`ICT_IRQ_CAP4] | cap_evt[1];
    nxt_irq_stat[`ICT_IRQ_CAP5] = nxt_irq_stat[`ICT_IRQ_CAP5] | cap_evt[2];
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irq_stat_ff <= `ICT_ZERO4;
      irq_mask_ff <= `ICT_ZERO4;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      if (reg_wr && reg_addr == `ICT_OFF_IRQ_MASK) begin
        irq_mask_ff <= reg_wdata[`ICT_IRQ_CAP5:`ICT_IRQ_WRAP];
      end
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // Read decode; unmapped addresses and idle cycles return zero.
  always_comb begin
    nxt_rdata = `ICT_ZERO32;
    case (reg_addr)
      `ICT_OFF_CTRL: nxt_rdata = {29'h0, cnt_rst_ff, enable_ff, active_ff};
      `ICT_OFF_CFG_LO: nxt_rdata = cfg_lo_ff;
      `ICT_OFF_CFG_HI: nxt_rdata = cfg_hi_ff;
      `ICT_OFF_COUNT: nxt_rdata = count_ff;
      `ICT_OFF_CAP0: nxt_rdata = cap_ff[0];
      `ICT_OFF_CAP4: nxt_rdata = cap_ff[1];
      `ICT_OFF_CAP5: nxt_rdata = cap_ff[2];
      `ICT_OFF_IRQ_STAT: nxt_rdata = {28'h0, irq_stat_ff};
      `ICT_OFF_IRQ_MASK: nxt_rdata = {28'h0, irq_mask_ff};
      default: nxt_rdata = `ICT_ZERO32;
    endcase
  end

  // Read data stands for exactly the cycle after the strobe.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      reg_rdata_ff <= `ICT_ZERO32;
    end else begin
      reg_rdata_ff <= reg_rd ? nxt_rdata : `ICT_ZERO32;
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign irq = irq_ff;

  // Checks kept next to the logic they guard.
  sequence s_rst_req;
    wr_ctrl && reg_wdata[`ICT_CTRL_RESET] && !cnt_rst_ff;
  endsequence

  sequence s_rst_done;
    cnt_rst_ff ##1 (!cnt_rst_ff && !enable_ff && count_ff == `ICT_ZERO32);
  endsequence

  property p_edge_field;
    @(posedge mclk) disable iff (!rst_b)
      reg_wr && reg_addr == `ICT_OFF_CFG_HI
      |=> f_edge(ch_cfg[2]) == $past(reg_wdata[`ICT_CH5_EDGE_HI:`ICT_CH5_EDGE_LO]);
  endproperty
  a_edge_field: assert property (p_edge_field) else $error("ch5 edge field misplaced");

  property p_edge_off;
    @(posedge mclk) disable iff (!rst_b)
      f_edge(ch_cfg[0]) == ict_pkg::ICT_EDGE_OFF |-> !cap_evt[0];
  endproperty
  a_edge_off: assert property (p_edge_off) else $error("capture while disabled");

  property p_skip;
    @(posedge mclk) disable iff (!rst_b)
      active_ff && ch_cfg[0][`ICT_FLD_SKIP] && f_edge(ch_cfg[0]) == ict_pkg::ICT_EDGE_BOTH
      && g_ch[0].clean_ff != g_ch[0].prev_ff |-> cap_evt[0];
  endproperty
  a_skip: assert property (p_skip) else $error("bypass not taken");

  property p_count_read;
    @(posedge mclk) disable iff (!rst_b)
      reg_rd && reg_addr == `ICT_OFF_COUNT |=> reg_rdata == $past(count_ff);
  endproperty
  a_count_read: assert property (p_count_read) else $error("count read wrong");

  property p_wrap_irq;
    @(posedge mclk) disable iff (!rst_b)
      wrap_evt && irq_mask_ff[`ICT_IRQ_WRAP] && !(reg_wr && reg_addr == `ICT_OFF_IRQ_MASK)
      |=> count_ff == `ICT_ZERO32 ##1 irq;
  endproperty
  a_wrap_irq: assert property (p_wrap_irq) else $error("wrap interrupt missing");

  property p_wr_ignored;
    @(posedge mclk) disable iff (!rst_b)
      wr_count && enable_ff && active_ff && !cnt_rst_ff |=> count_ff == $past(count_ff) + 32'h1;
  endproperty
  a_wr_ignored: assert property (p_wr_ignored) else $error("write while enabled");

  property p_capture;
    @(posedge mclk) disable iff (!rst_b)
      cap_evt[0] |=> cap_ff[0] == $past(count_ff) && irq_stat_ff[`ICT_IRQ_CAP0];
  endproperty
  a_capture: assert property (p_capture) else $error("capture 0 wrong");

  property p_cnt_reset;
    @(posedge mclk) disable iff (!rst_b)
      s_rst_req |=> s_rst_done;
  endproperty
  a_cnt_reset: assert property (p_cnt_reset) else $error("counter reset wrong");

  property p_hold;
    @(posedge mclk) disable iff (!rst_b)
      !enable_ff && !cnt_rst_ff && !wr_count |=> count_ff == $past(count_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while stopped");

  // Running means one step per clock, so the all-ones value rolls over to zero.
  property p_count_up;
    @(posedge mclk) disable iff (!rst_b)
      active_ff && enable_ff && !cnt_rst_ff |=> count_ff == $past(count_ff) + 32'h00000001;
  endproperty
  a_count_up: assert property (p_count_up) else $error("count did not advance");

  // The line lags the status by one register stage and never misses a set bit whose mask bit is set.
  property p_irq_level;
    @(posedge mclk) disable iff (!rst_b)
      (|(irq_stat_ff & irq_mask_ff)) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt line low");

endmodule : ict_timer

// ==== sim/ict_pin_model.sv ====
// Far-side model: capture pin drivers and the interrupt aggregator.
`timescale 1ns/1ps
module ict_pin_model (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Pin levels requested by the bench.
  input wire logic [2:0] lvl_cmd,
  // Capture pins.
  output logic pin_ch0,
  output logic pin_ch4,
  output logic pin_ch5,
  // Interrupt line and rise count.
  input wire logic irq,
  output logic [7:0] irq_rises
);
  logic irq_ff;

  // Pins move a few ns after the request, so a pin edge never lands on a clock edge.
  assign #3 {pin_ch5, pin_ch4, pin_ch0} = lvl_cmd;

  // The aggregator sees a level, so it counts rises to spot a stuck or chattering line.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irq_ff <= 1'b0;
      irq_rises <= 8'h00;
    end else begin
      irq_ff <= irq;
      if (irq && !irq_ff) begin
        irq_rises <= irq_rises + 8'h01;
      end
    end
  end
endmodule : ict_pin_model

// ==== sim/tb_top.sv ====
// Self-checking bench of the input capture timer.
`timescale 1ns/1ps
`include "ict_cfg.svh"
`define CHK(nm, e, a) tests_run++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR %s exp %h got %h", nm, e, a); end
module tb_top;
  logic mclk, rst_b, reg_wr, reg_rd, irq, pin_ch0, pin_ch4, pin_ch5, ex;
  logic [7:0] reg_addr, irq_rises;
  logic [31:0] reg_wdata, reg_rdata, rv, c1, val, last;
  logic [2:0] lvl_cmd;
  int fail_count = 0;
  int tests_run = 0;

  // Short filter keeps the filtered path quick to observe.
  ict_timer #(.FILT_LEN(1), .DIV_W(8)) ict_timer_inst (.mclk(mclk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .capture_input_ch0(pin_ch0), .capture_input_ch4(pin_ch4),
    .capture_input_ch5(pin_ch5), .irq(irq));
  ict_pin_model ict_pin_model_inst (.mclk(mclk), .rst_b(rst_b), .lvl_cmd(lvl_cmd),
    .pin_ch0(pin_ch0), .pin_ch4(pin_ch4), .pin_ch5(pin_ch5), .irq(irq),
    .irq_rises(irq_rises));

  // Clock of 10 ns.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // One-cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data are valid only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // Reset values, writable config bits, read-only capture, unmapped address.
  task automatic t_map();
    rd(`ICT_OFF_COUNT, rv);
    `CHK("count_rst", 32'h00000000, rv)
    rd(8'h40, rv);
    `CHK("unmapped", 32'h00000000, rv)
    wr(`ICT_OFF_CFG_LO, 32'hFFFFFFFF);
    rd(`ICT_OFF_CFG_LO, rv);
    `CHK("cfg_lo", 32'h000000E7, rv)
    wr(`ICT_OFF_CFG_HI, 32'hFFFFFFFF);
    rd(`ICT_OFF_CFG_HI, rv);
    `CHK("cfg_hi", 32'h0000E7E7, rv)
    wr(`ICT_OFF_CAP0, 32'h0000ABCD);
    rd(`ICT_OFF_CAP0, rv);
    `CHK("cap0_ro", 32'h00000000, rv)
  endtask : t_map

  // Load while stopped, ignored write while running, stop, counter reset.
  task automatic t_count();
    wr(`ICT_OFF_COUNT, 32'h00000100);
    rd(`ICT_OFF_COUNT, rv);
    `CHK("count_load", 32'h00000100, rv)
    wr(`ICT_OFF_CTRL, 32'h00000003);
    wr(`ICT_OFF_COUNT, 32'h00000005);
    rd(`ICT_OFF_COUNT, c1);
    `CHK("count_runs", 1'b1, (c1 > 32'h00000100) && (c1 < 32'h00000120))
    wr(`ICT_OFF_CTRL, 32'h00000001);
    rd(`ICT_OFF_COUNT, c1);
    repeat (5) @(posedge mclk);
    rd(`ICT_OFF_COUNT, rv);
    `CHK("count_held", c1, rv)
    wr(`ICT_OFF_CTRL, 32'h00000007);
    repeat (2) @(posedge mclk);
    rd(`ICT_OFF_CTRL, rv);
    `CHK("ctrl_after_rst", 32'h00000001, rv)
    rd(`ICT_OFF_COUNT, rv);
    `CHK("count_zeroed", 32'h00000000, rv)
  endtask : t_count

  // Wrap sets status; mask gates the line; write-one clears it.
  task automatic t_wrap();
    wr(`ICT_OFF_COUNT, 32'hFFFFFFF0);
    wr(`ICT_OFF_CTRL, 32'h00000003);
    repeat (30) @(negedge mclk);
    rd(`ICT_OFF_IRQ_STAT, rv);
    `CHK("wrap_stat", 1'b1, rv[0])
    `CHK("irq_masked", 1'b0, irq)
    wr(`ICT_OFF_IRQ_MASK, 32'h00000001);
    repeat (2) @(negedge mclk);
    `CHK("irq_on", 1'b1, irq)
    wr(`ICT_OFF_IRQ_STAT, 32'h00000001);
    repeat (2) @(negedge mclk);
    `CHK("irq_off", 1'b0, irq)
    `CHK("agg_rises", 8'h01, irq_rises)
    wr(`ICT_OFF_CTRL, 32'h00000001);
    wr(`ICT_OFF_COUNT, 32'hFFFFFFF8);
    wr(`ICT_OFF_CTRL, 32'h00000003);
    repeat (20) @(negedge mclk);
    `CHK("irq_unmasked_wrap", 1'b1, irq)
    `CHK("agg_rises2", 8'h02, irq_rises)
    wr(`ICT_OFF_IRQ_STAT, 32'h00000001);
    wr(`ICT_OFF_CTRL, 32'h00000001);
  endtask : t_wrap

  // Every edge code against both pin directions, counter stopped at a known value.
  task automatic t_edges();
    last = 32'h00000000;
    for (int e = 0; e < 5; e++) begin
      for (int d = 0; d < 2; d++) begin
        val = 32'(4096 + e * 2 + d);
        wr(`ICT_OFF_CFG_LO, (e == 4) ? 32'h00000002 : 32'(4 + e));
        wr(`ICT_OFF_COUNT, val);
        wr(`ICT_OFF_IRQ_STAT, 32'h0000000F);
        lvl_cmd[0] <= (d == 0);
        repeat (12) @(posedge mclk);
        rd(`ICT_OFF_IRQ_STAT, rv);
        ex = (e == 2) || (e == 4) || (e == 1 && d == 0) || (e == 0 && d == 1);
        `CHK("cap0_event", ex, rv[1])
        last = ex ? val : last;
        rd(`ICT_OFF_CAP0, rv);
        `CHK("cap0_value", last, rv)
      end
    end
  endtask : t_edges

  // Channels 4 and 5 on rising edges, then no event while the block is inactive.
  task automatic t_ch45();
    wr(`ICT_OFF_CFG_HI, 32'h00000505);
    wr(`ICT_OFF_COUNT, 32'h00002222);
    wr(`ICT_OFF_IRQ_STAT, 32'h0000000F);
    lvl_cmd[2:1] <= 2'b11;
    repeat (12) @(posedge mclk);
    rd(`ICT_OFF_IRQ_STAT, rv);
    `CHK("ch45_event", 2'b11, rv[3:2])
    rd(`ICT_OFF_CAP4, rv);
    `CHK("cap4_value", 32'h00002222, rv)
    rd(`ICT_OFF_CAP5, rv);
    `CHK("cap5_value", 32'h00002222, rv)
    wr(`ICT_OFF_CFG_HI, 32'h000005E2);
    wr(`ICT_OFF_IRQ_STAT, 32'h0000000F);
    lvl_cmd[1] <= 1'b0;
    repeat (140) @(posedge mclk);
    rd(`ICT_OFF_IRQ_STAT, rv);
    `CHK("ch4_slow_filter", 1'b1, rv[2])
    wr(`ICT_OFF_CTRL, 32'h00000000);
    wr(`ICT_OFF_CFG_LO, 32'h00000006);
    wr(`ICT_OFF_IRQ_STAT, 32'h0000000F);
    lvl_cmd[0] <= ~lvl_cmd[0];
    repeat (12) @(posedge mclk);
    rd(`ICT_OFF_IRQ_STAT, rv);
    `CHK("inactive", 1'b0, rv[1])
  endtask : t_ch45

  // Verdict and end of run.
  task automatic summarize();
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  // Main sequence after an eight-cycle reset.
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    lvl_cmd = 3'h0;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    t_map();
    t_count();
    t_wrap();
    t_edges();
    t_ch45();
    summarize();
  end

  // The run needs under 2000 cycles; a hang is cut well beyond that.
  initial begin
    #100000;
    fail_count++;
    summarize();
  end
endmodule : tb_top
